// ==== shared/csp_pkg.sv ====
// package: constants and types of the configuration status pin block
`default_nettype none
package csp_pkg;
  // **************************************************************
  // timing
  // **************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MASTER_WAIT_MIN_US = 30;
  localparam int MASTER_WAIT_MAX_US = 300;
  // least time rounds up; 30 us at 10 ns
  localparam int MASTER_WAIT_CYCLES = (MASTER_WAIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_STABLE_CYCLES = 16;
  localparam int CLEAR_CYCLES = 64;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  // **************************************************************
  // boundary scan
  // **************************************************************
  localparam int CELLS_PER_IO = 3;
  localparam int NUM_IO = 4;
  localparam int SCAN_LEN = CELLS_PER_IO * NUM_IO;
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_RESET = 4'hF;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] IR_CFG = 4'h5;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  typedef enum logic [2:0] {
    CSP_POWER, CSP_CLEAR, CSP_WAIT, CSP_DELAY, CSP_CONFIG, CSP_ACTIVE
  } csp_phase_e;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } csp_tap_e;
endpackage : csp_pkg
`default_nettype wire

// ==== shared/csp_scan_if.sv ====
// interface: synchronised test pins and scan results between top and tap
`default_nettype none
interface csp_scan_if;
  import csp_pkg::*;
  logic tckRise;
  logic tdi;
  logic tms;
  logic scanEnable;
  logic tdo;
  logic tdoEnable;
  logic cfgBit;
  logic cfgStrobe;
  logic [SCAN_LEN-1:0] captureCells;
  modport top (output tckRise, output tdi, output tms, output scanEnable, output captureCells,
               input tdo, input tdoEnable, input cfgBit, input cfgStrobe);
  modport tap (input tckRise, input tdi, input tms, input scanEnable, input captureCells,
               output tdo, output tdoEnable, output cfgBit, output cfgStrobe);
endinterface : csp_scan_if
`default_nettype wire

// ==== core/csp_sync.sv ====
// module: three-stage pin synchroniser with agreement filter
`default_nettype none
module csp_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pin and clean level
  input wire logic pin,
  output logic level
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_level;

  always_comb begin
    next_stage = {stage[1:0], pin};
    // first stage is read only by the second
    next_level = (stage[2] == stage[1]) ? stage[1] : level;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 3'h7;
      level <= 1'b1;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end
endmodule : csp_sync
`default_nettype wire

// ==== core/csp_tap.sv ====
// module: boundary-scan test access port, instruction and data registers
`default_nettype none
module csp_tap
  import csp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // scan channel
  csp_scan_if.tap scan
);
  csp_tap_e state;
  csp_tap_e next_state;
  logic [IR_W-1:0] irShift;
  logic [IR_W-1:0] next_irShift;
  logic [IR_W-1:0] ir;
  logic [IR_W-1:0] next_ir;
  logic [SCAN_LEN-1:0] bsr;
  logic [SCAN_LEN-1:0] next_bsr;
  logic bypassBit;
  logic next_bypassBit;
  logic next_tdo;
  logic next_tdoEnable;
  logic next_cfgBit;
  logic next_cfgStrobe;

  function automatic csp_tap_e tapNext(input csp_tap_e s, input logic tms);
    case (s)
      TAP_RESET: tapNext = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tapNext = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tapNext = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tapNext = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tapNext = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tapNext = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: tapNext = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tapNext = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tapNext = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tapNext = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tapNext = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tapNext = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tapNext = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: tapNext = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tapNext = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tapNext = tms ? TAP_SEL_DR : TAP_IDLE;
      default: tapNext = TAP_RESET;
    endcase
  endfunction : tapNext

  always_comb begin
    next_state = state;
    next_irShift = irShift;
    next_ir = ir;
    next_bsr = bsr;
    next_bypassBit = bypassBit;
    next_tdo = scan.tdo;
    next_tdoEnable = scan.tdoEnable;
    next_cfgBit = scan.cfgBit;
    next_cfgStrobe = 1'b0;
    if (!scan.scanEnable) begin
      // scan disabled: controller held in reset
      next_state = TAP_RESET;
      next_ir = IR_RESET;
      next_tdoEnable = 1'b0;
    end else if (scan.tckRise) begin
      next_state = tapNext(state, scan.tms);
      case (state)
        TAP_RESET: next_ir = IR_RESET;
        TAP_CAP_IR: next_irShift = IR_CAPTURE;
        TAP_SH_IR: next_irShift = {scan.tdi, irShift[IR_W-1:1]};
        TAP_UPD_IR: next_ir = irShift;
        TAP_CAP_DR: begin
          if (ir == IR_EXTEST || ir == IR_SAMPLE) begin
            next_bsr = scan.captureCells;
          end
          next_bypassBit = 1'b0;
        end
        TAP_SH_DR: begin
          if (ir == IR_EXTEST || ir == IR_SAMPLE) begin
            next_bsr = {scan.tdi, bsr[SCAN_LEN-1:1]};
          end else if (ir == IR_CFG) begin
            next_cfgBit = scan.tdi;
            next_cfgStrobe = 1'b1;
          end
          next_bypassBit = scan.tdi;
        end
        default: begin
        end
      endcase
      // tdo changes on the same tck rise as the shift-state decision
      case (next_state)
        TAP_SH_IR: next_tdo = irShift[0];
        TAP_SH_DR: next_tdo = (ir == IR_EXTEST || ir == IR_SAMPLE) ? next_bsr[0] : next_bypassBit;
        default: next_tdo = scan.tdo;
      endcase
      next_tdoEnable = (next_state == TAP_SH_IR) || (next_state == TAP_SH_DR);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TAP_RESET;
      irShift <= IR_RESET;
      ir <= IR_RESET;
      bsr <= '0;
      bypassBit <= 1'b0;
      scan.tdo <= 1'b0;
      scan.tdoEnable <= 1'b0;
      scan.cfgBit <= 1'b0;
      scan.cfgStrobe <= 1'b0;
    end else begin
      state <= next_state;
      irShift <= next_irShift;
      ir <= next_ir;
      bsr <= next_bsr;
      bypassBit <= next_bypassBit;
      scan.tdo <= next_tdo;
      scan.tdoEnable <= next_tdoEnable;
      scan.cfgBit <= next_cfgBit;
      scan.cfgStrobe <= next_cfgStrobe;
    end
  end
endmodule : csp_tap
`default_nettype wire

// ==== core/config_status_pins.sv ====
// module: configuration status, init handshake and test-pin hand-over
// **************************************************************
// **************************************************************
`default_nettype none
module config_status_pins
  import csp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // options
  input wire logic masterMode,
  input wire logic scanPrimitiveUsed,
  // configuration engine
  input wire logic cfgDataError,
  input wire logic cfgDone,
  output logic ioActive,
  output logic cfgBusy,
  output logic scanCfgBit,
  output logic scanCfgStrobe,
  // busy indicator pins
  input wire logic userHighOut,
  input wire logic userHighOe,
  input wire logic userLowOut,
  input wire logic userLowOe,
  output logic busyHighOut,
  output logic busyHighOe,
  output logic busyLowOut,
  output logic busyLowOe,
  // init pin
  input wire logic initIn,
  input wire logic userInitOut,
  input wire logic userInitOe,
  output logic initOut,
  output logic initOe,
  output logic userInitIn,
  // test pins
  input wire logic tdiIn,
  input wire logic tckIn,
  input wire logic tmsIn,
  input wire logic [NUM_IO-1:0] ioPadIn,
  input wire logic userTestOut,
  input wire logic userTestOe,
  output logic tdoOut,
  output logic tdoOe,
  output logic userTdi,
  output logic userTck,
  output logic userTms
);
  // **************************************************************
  // synchronisers
  // **************************************************************
  logic initLevel;
  logic tdiLevel;
  logic tckLevel;
  logic tmsLevel;

  csp_sync uInitSync (.mclk(mclk), .rst_n(rst_n), .pin(initIn), .level(initLevel));
  csp_sync uTdiSync (.mclk(mclk), .rst_n(rst_n), .pin(tdiIn), .level(tdiLevel));
  csp_sync uTckSync (.mclk(mclk), .rst_n(rst_n), .pin(tckIn), .level(tckLevel));
  csp_sync uTmsSync (.mclk(mclk), .rst_n(rst_n), .pin(tmsIn), .level(tmsLevel));

  // **************************************************************
  // configuration phase sequencer
  // **************************************************************
  csp_phase_e phase;
  csp_phase_e next_phase;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic errorSeen;
  logic next_errorSeen;

  always_comb begin
    next_phase = phase;
    next_count = (count == CNT_ZERO) ? CNT_ZERO : count - 16'h0001;
    next_errorSeen = errorSeen;
    case (phase)
      CSP_POWER: begin
        if (count == CNT_ZERO) begin
          next_phase = CSP_CLEAR;
          next_count = CNT_W'(CLEAR_CYCLES - 1);
        end
      end
      CSP_CLEAR: begin
        if (count == CNT_ZERO) begin
          next_phase = CSP_WAIT;
        end
      end
      CSP_WAIT: begin
        // host holding init low keeps us here
        if (initLevel) begin
          if (masterMode) begin
            next_phase = CSP_DELAY;
            next_count = CNT_W'(MASTER_WAIT_CYCLES - 1);
          end else begin
            next_phase = CSP_CONFIG;
          end
        end
      end
      CSP_DELAY: begin
        if (!initLevel) begin
          next_phase = CSP_WAIT;
        end else if (count == CNT_ZERO) begin
          next_phase = CSP_CONFIG;
        end
      end
      CSP_CONFIG: begin
        if (cfgDataError) begin
          next_errorSeen = 1'b1;
        end
        if (cfgDone && !errorSeen && !cfgDataError) begin
          next_phase = CSP_ACTIVE;
        end
      end
      CSP_ACTIVE: begin
      end
      default: next_phase = CSP_POWER;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= CSP_POWER;
      count <= CNT_W'(POWER_STABLE_CYCLES - 1);
      errorSeen <= 1'b0;
    end else begin
      phase <= next_phase;
      count <= next_count;
      errorSeen <= next_errorSeen;
    end
  end

  // **************************************************************
  // pin muxing, all registered
  // **************************************************************
  logic active;
  logic scanOn;
  logic tckLevelDly;
  logic next_tckLevelDly;
  logic [SCAN_LEN-1:0] cells;
  logic next_ioActive;
  logic next_cfgBusy;
  logic next_busyHighOut;
  logic next_busyHighOe;
  logic next_busyLowOut;
  logic next_busyLowOe;
  logic next_initOut;
  logic next_initOe;
  logic next_userInitIn;
  logic next_tdoOut;
  logic next_tdoOe;
  logic next_userTdi;
  logic next_userTck;
  logic next_userTms;
  logic next_scanCfgBit;
  logic next_scanCfgStrobe;

  csp_scan_if scanBus ();

  // per io block: input, output and enable cells
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IO; gi++) begin : gCells
      assign cells[gi*CELLS_PER_IO] = ioPadIn[gi];
      assign cells[gi*CELLS_PER_IO+1] = userTestOut;
      assign cells[gi*CELLS_PER_IO+2] = userTestOe;
    end
  endgenerate

  assign active = (phase == CSP_ACTIVE);
  // scan stays alive during configuration; afterwards only if the primitive is placed
  assign scanOn = !active || scanPrimitiveUsed;
  assign scanBus.tckRise = tckLevel && !tckLevelDly;
  assign scanBus.tdi = tdiLevel;
  assign scanBus.tms = tmsLevel;
  assign scanBus.scanEnable = scanOn;
  assign scanBus.captureCells = cells;

  csp_tap uTap (.mclk(mclk), .rst_n(rst_n), .scan(scanBus));

  always_comb begin
    next_tckLevelDly = tckLevel;
    next_ioActive = active;
    next_cfgBusy = !active;
    // busy indicators during configuration, user afterwards
    next_busyHighOut = active ? userHighOut : 1'b1;
    next_busyHighOe = active ? userHighOe : 1'b1;
    next_busyLowOut = active ? userLowOut : 1'b0;
    next_busyLowOe = active ? userLowOe : 1'b1;
    // open drain: only ever drive low while configuring
    next_initOut = 1'b0;
    case (phase)
      CSP_POWER, CSP_CLEAR: next_initOe = 1'b1;
      CSP_CONFIG: next_initOe = errorSeen || cfgDataError;
      CSP_ACTIVE: begin
        next_initOut = userInitOut;
        next_initOe = userInitOe;
      end
      default: next_initOe = 1'b0;
    endcase
    next_userInitIn = active ? initLevel : 1'b1;
    next_tdoOut = scanOn ? scanBus.tdo : userTestOut;
    next_tdoOe = scanOn ? scanBus.tdoEnable : (active && userTestOe);
    // readable by user logic after configuration in both cases
    next_userTdi = active ? tdiLevel : 1'b0;
    next_userTck = active ? tckLevel : 1'b0;
    next_userTms = active ? tmsLevel : 1'b0;
    next_scanCfgBit = scanBus.cfgBit;
    next_scanCfgStrobe = scanBus.cfgStrobe && !active;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tckLevelDly <= 1'b1;
      ioActive <= 1'b0;
      cfgBusy <= 1'b1;
      busyHighOut <= 1'b1;
      busyHighOe <= 1'b1;
      busyLowOut <= 1'b0;
      busyLowOe <= 1'b1;
      initOut <= 1'b0;
      initOe <= 1'b1;
      userInitIn <= 1'b1;
      tdoOut <= 1'b0;
      tdoOe <= 1'b0;
      userTdi <= 1'b0;
      userTck <= 1'b0;
      userTms <= 1'b0;
      scanCfgBit <= 1'b0;
      scanCfgStrobe <= 1'b0;
    end else begin
      tckLevelDly <= next_tckLevelDly;
      ioActive <= next_ioActive;
      cfgBusy <= next_cfgBusy;
      busyHighOut <= next_busyHighOut;
      busyHighOe <= next_busyHighOe;
      busyLowOut <= next_busyLowOut;
      busyLowOe <= next_busyLowOe;
      initOut <= next_initOut;
      initOe <= next_initOe;
      userInitIn <= next_userInitIn;
      tdoOut <= next_tdoOut;
      tdoOe <= next_tdoOe;
      userTdi <= next_userTdi;
      userTck <= next_userTck;
      userTms <= next_userTms;
      scanCfgBit <= next_scanCfgBit;
      scanCfgStrobe <= next_scanCfgStrobe;
    end
  end
endmodule : config_status_pins
`default_nettype wire

// ==== test/csp_host_model.sv ====
// model: host side of the init line with its pull-up and a hold-low control
`default_nettype none
module csp_host_model (
  // device drive
  input wire logic initOe,
  input wire logic initOut,
  // host control
  input wire logic holdLow,
  // resolved line
  output logic initLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // line
  // ****
  // released line goes to the pull-up level, never keeps the last driven value
  always_comb begin
    if (holdLow || (initOe && !initOut)) begin
      initLine = 1'b0;
    end else begin
      initLine = 1'b1;
    end
  end
endmodule : csp_host_model
`default_nettype wire

// ==== test/csp_checker_assertions.sv ====
// checker: port assertions of the configuration status pin block
`default_nettype none
module csp_checker
  import csp_pkg::*;
(
  // clock, reset, options
  input wire logic mclk, rst_n, masterMode, scanPrimitiveUsed, cfgDone,
  // status and user drive
  input wire logic ioActive, cfgBusy, userHighOut, userHighOe, userLowOut, userLowOe, userInitOut, userInitOe,
  // pins
  input wire logic busyHighOut, busyHighOe, busyLowOut, busyLowOe, initIn, initOut, initOe, userInitIn,
  input wire logic tdoOe, userTdi, userTck, userTms, userTestOe
);
  // ****
  // counters
  // ****
  logic [15:0] age;
  logic [15:0] next_age;
  logic [15:0] highRun;
  logic [15:0] next_highRun;
  always_comb begin
    next_age = age + {15'h0000, age != 16'hFFFF};
    // run of high init while the device has let go
    next_highRun = (!initIn || initOe) ? 16'h0000 : highRun + {15'h0000, highRun != 16'hFFFF};
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      age <= 16'h0000;
      highRun <= 16'h0000;
    end else begin
      age <= next_age;
      highRun <= next_highRun;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_activation;
    !ioActive ##1 ioActive;
  endsequence
  sequence s_error_latch;
    // hand-over edge may raise initOe from user drive, so the rise must stay in configuration
    (!ioActive && !initOe) ##1 (initOe && !ioActive);
  endsequence
  a_busy_high_cfg: assert property (!ioActive |-> busyHighOut && busyHighOe)
    else $error("high busy pin not driven");
  a_busy_low_cfg: assert property (!ioActive |-> !busyLowOut && busyLowOe)
    else $error("low busy pin not driven");
  a_busy_user_pass: assert property (ioActive && $past(ioActive) |-> busyHighOut == $past(userHighOut)
    && busyHighOe == $past(userHighOe) && busyLowOut == $past(userLowOut) && busyLowOe == $past(userLowOe))
    else $error("busy pins not handed to user");
  a_active_hold: assert property (ioActive |=> ioActive && !cfgBusy)
    else $error("active state lost");
  a_done_cause: assert property (s_activation |-> $past(cfgDone, 2) && !$past(initOe))
    else $error("activation without clean done");
  a_init_open_drain: assert property (!ioActive |-> !initOut)
    else $error("init driven high in configuration");
  a_clear_hold: assert property (age < 16'h0050 |-> initOe)
    else $error("init released during clearing");
  a_init_release: assert property (age == 16'h0064 && !ioActive |-> !initOe)
    else $error("init not released after clearing");
  a_master_wait: assert property (s_activation |-> !masterMode || highRun >= MASTER_WAIT_CYCLES)
    else $error("master wait too short");
  a_error_latch: assert property (s_error_latch |=> (initOe && !ioActive) [*8])
    else $error("error report not held");
  a_init_user: assert property (ioActive && $past(ioActive) |-> initOut == $past(userInitOut)
    && initOe == $past(userInitOe))
    else $error("init not handed to user");
  a_test_idle: assert property (!ioActive |-> !userTdi && !userTck && !userTms && userInitIn)
    else $error("user pins leaked before active");
  a_scan_off: assert property (ioActive && $past(ioActive) && !scanPrimitiveUsed |-> tdoOe == $past(userTestOe))
    else $error("test output not handed to user");
endmodule : csp_checker
bind config_status_pins csp_checker i_chk (.mclk, .rst_n, .masterMode, .scanPrimitiveUsed, .cfgDone, .ioActive,
  .cfgBusy, .userHighOut, .userHighOe, .userLowOut, .userLowOe, .userInitOut, .userInitOe, .busyHighOut,
  .busyHighOe, .busyLowOut, .busyLowOe, .initIn, .initOut, .initOe, .userInitIn, .tdoOe, .userTdi, .userTck,
  .userTms, .userTestOe);
`default_nettype wire

// ==== test/tb.sv ====
// testbench: init handshake, master wait, scan load, error report and pin hand-over
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
`define WAITF(c, lim) begin for (n = 0; n < (lim) && !(c); n++) @(posedge mclk); `CHK("wait", 1'b1, (c)) end
module tb
  import csp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals
  // ****
  int errors = 0;
  int checked = 0;
  int n;
  int i;
  int strobes = 0;
  int seed = 32'h18cc;
  logic [31:0] r;
  logic [7:0] sentBits;
  logic [7:0] gotBits = 8'h00;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic masterMode = 1'b0, scanPrimitiveUsed = 1'b0, cfgDataError = 1'b0, cfgDone = 1'b0, holdLow = 1'b0;
  logic userHighOut = 1'b0, userHighOe = 1'b0, userLowOut = 1'b0, userLowOe = 1'b0;
  logic userInitOut = 1'b0, userInitOe = 1'b0, userTestOut = 1'b0, userTestOe = 1'b0;
  logic tdiIn = 1'b0, tckIn = 1'b0, tmsIn = 1'b0;
  logic [NUM_IO-1:0] ioPadIn = {NUM_IO{1'b0}};
  logic ioActive, cfgBusy, scanCfgBit, scanCfgStrobe, busyHighOut, busyHighOe, busyLowOut, busyLowOe;
  logic initLine, initOut, initOe, userInitIn, tdoOut, tdoOe, userTdi, userTck, userTms;

  always #5 mclk = ~mclk;

  config_status_pins i_dut (.mclk, .rst_n, .masterMode, .scanPrimitiveUsed, .cfgDataError, .cfgDone, .ioActive,
    .cfgBusy, .scanCfgBit, .scanCfgStrobe, .userHighOut, .userHighOe, .userLowOut, .userLowOe, .busyHighOut,
    .busyHighOe, .busyLowOut, .busyLowOe, .initIn(initLine), .userInitOut, .userInitOe, .initOut, .initOe,
    .userInitIn, .tdiIn, .tckIn, .tmsIn, .ioPadIn, .userTestOut, .userTestOe, .tdoOut, .tdoOe, .userTdi,
    .userTck, .userTms);
  csp_host_model i_host (.initOe, .initOut, .holdLow, .initLine);

  // collect bits loaded through the scan port, first bit ends in bit 0
  always @(posedge mclk) begin
    if (scanCfgStrobe === 1'b1) begin
      gotBits <= {scanCfgBit, gotBits[7:1]};
      strobes <= strobes + 1;
    end
  end
  // ****
  // helpers
  // ****
  function automatic logic [3:0] exp_busy(input logic act, input logic [3:0] usr);
    return act ? usr : 4'hD;
  endfunction : exp_busy

  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic restart(input logic master, input logic scanUsed);
    @(posedge mclk);
    rst_n <= 1'b0;
    masterMode <= master;
    scanPrimitiveUsed <= scanUsed;
    cfgDone <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : restart

  // slow test clock: every level held well past the synchroniser
  task automatic tck_bit(input logic tms, input logic tdi);
    @(posedge mclk);
    tmsIn <= tms;
    tdiIn <= tdi;
    repeat (6) @(posedge mclk);
    tckIn <= 1'b1;
    repeat (6) @(posedge mclk);
    tckIn <= 1'b0;
  endtask : tck_bit

  task automatic scan_load();
    r = $random(seed);
    sentBits = r[7:0];
    for (i = 0; i < 6; i++) tck_bit(i < 5, 1'b0);
    for (i = 0; i < 4; i++) tck_bit(i < 2, 1'b0);
    for (i = 0; i < 4; i++) tck_bit(i == 3, IR_CFG[i]);
    for (i = 0; i < 5; i++) tck_bit(i == 0 || i == 2, 1'b0);
    for (i = 0; i < 8; i++) tck_bit(i == 7, sentBits[i]);
    tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
    repeat (10) @(negedge mclk);
    `CHK("cfg strobes", 8, strobes)
    `CHK("cfg bits", sentBits, gotBits)
  endtask : scan_load

  task automatic pins_follow();
    @(posedge mclk);
    r = $random(seed);
    {tdiIn, tckIn, tmsIn} <= r[2:0];
    repeat (10) @(negedge mclk);
    `CHK("user test pins", r[2:0], {userTdi, userTck, userTms})
    `CHK("test out pin", (scanPrimitiveUsed ? 2'h0 : {userTestOut, userTestOe}), {tdoOut, tdoOe})
    `CHK("user init in", (!(userInitOe && !userInitOut)), userInitIn)
  endtask : pins_follow
  // ****
  // sequence
  // ****
  initial begin
    restart(1'b0, 1'b0);
    @(negedge mclk);
    `CHK("busy pins", exp_busy(1'b0, 4'h0), {busyHighOut, busyHighOe, busyLowOut, busyLowOe})
    `CHK("init drive", 2'h1, {initOut, initOe})
    `WAITF(initOe === 1'b0, 120)
    repeat (10) @(posedge mclk);
    scan_load();
    @(posedge mclk);
    cfgDone <= 1'b1;
    `WAITF(ioActive === 1'b1, 10)
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      r = $random(seed);
      {userHighOut, userHighOe, userLowOut, userLowOe} <= r[3:0];
      {userInitOut, userInitOe, userTestOut, userTestOe} <= r[7:4];
      ioPadIn <= r[NUM_IO+7:8];
      @(posedge mclk);
      @(negedge mclk);
      `CHK("busy pins", exp_busy(1'b1, r[3:0]), {busyHighOut, busyHighOe, busyLowOut, busyLowOe})
      `CHK("init pin", r[7:6], {initOut, initOe})
    end
    pins_follow();
    @(posedge mclk);
    holdLow <= 1'b1;
    restart(1'b1, 1'b1);
    cfgDone <= 1'b1;
    repeat (300) @(negedge mclk);
    `CHK("held in wait", 1'b0, ioActive)
    @(posedge mclk);
    holdLow <= 1'b0;
    for (n = 0; n < 30000 && ioActive !== 1'b1; n++) @(posedge mclk);
    `CHK("master wait", 1'b1, n >= MASTER_WAIT_CYCLES && n < 30000)
    pins_follow();
    restart(1'b0, 1'b0);
    `WAITF(initOe === 1'b0, 120)
    repeat (40) @(posedge mclk);
    cfgDataError <= 1'b1;
    @(posedge mclk);
    cfgDataError <= 1'b0;
    cfgDone <= 1'b1;
    repeat (30) @(negedge mclk);
    `CHK("error report", 3'h4, {initOe, initLine, ioActive})
    end_sim();
  end
endmodule : tb
`default_nettype wire
